//--- logic/sdpo_host.sv
// controller end: AXI4-Lite command registers driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sdpo_host (
  // system clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  sdpo_link_if.host link,
  // axi4-lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_hold, w_hold, start, next_aw_hold, next_w_hold, next_start;
  logic [3:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, cmd_word, next_cmd_word;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic miso_s1, miso_s2;
  sdpo_pkg::sdpo_state_t state, next_state;
  logic [4:0] cnt, next_cnt, bit_cnt, next_bit_cnt;
  logic [31:0] tx_shift, next_tx_shift, rx_shift, next_rx_shift, resp_word, next_resp_word;
  logic next_sclk, next_cs_n, next_mosi;

  // register slave; a command written while busy is dropped
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_cmd_word = cmd_word;
    next_start = 1'b0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !s_axi_bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = sdpo_pkg::RESP_SLVERR;
      if (aw_addr == sdpo_pkg::REG_CMD) begin
        next_bresp = sdpo_pkg::RESP_OKAY;
        if (state == sdpo_pkg::SDPO_IDLE && !start) begin
          next_cmd_word = w_data;
          next_start = 1'b1;
        end
      end else if (aw_addr == sdpo_pkg::REG_STATUS || aw_addr == sdpo_pkg::REG_RESP) begin
        next_bresp = sdpo_pkg::RESP_OKAY;
      end
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = sdpo_pkg::RESP_OKAY;
      case (s_axi_araddr[3:0])
        sdpo_pkg::REG_CMD: next_rdata = cmd_word;
        sdpo_pkg::REG_STATUS: next_rdata = {31'h00000000, state != sdpo_pkg::SDPO_IDLE};
        sdpo_pkg::REG_RESP: next_rdata = resp_word;
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = sdpo_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      cmd_word <= 32'h00000000;
      start <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      cmd_word <= next_cmd_word;
      start <= next_start;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready | (!s_axi_arready && !s_axi_rvalid && !next_rvalid);
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // miso comes from the other end, so it is synchronised first
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
    end
  end

  // link sequencer: mode 0, msb first; half period outlasts the sync delay
  always_comb begin
    next_state = state;
    next_cnt = 5'(cnt + 5'h01);
    next_bit_cnt = bit_cnt;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_resp_word = resp_word;
    next_sclk = link.sclk;
    next_cs_n = link.cs_n;
    next_mosi = link.mosi;
    case (state)
      sdpo_pkg::SDPO_IDLE: begin
        next_cnt = 5'h00;
        if (start) begin
          next_state = sdpo_pkg::SDPO_LEAD;
          next_tx_shift = cmd_word;
          next_mosi = cmd_word[31];
          next_cs_n = 1'b0;
          next_bit_cnt = 5'h00;
        end
      end
      sdpo_pkg::SDPO_LEAD: begin
        if (cnt == 5'(sdpo_pkg::HALF_CYCLES - 5'h01)) begin
          next_cnt = 5'h00;
          next_state = sdpo_pkg::SDPO_SHIFT;
        end
      end
      sdpo_pkg::SDPO_SHIFT: begin
        if (cnt == 5'(sdpo_pkg::HALF_CYCLES - 5'h01)) begin
          next_cnt = 5'h00;
          if (!link.sclk) begin
            next_sclk = 1'b1;
            next_rx_shift = {rx_shift[30:0], miso_s2};
          end else begin
            next_sclk = 1'b0;
            if (bit_cnt == sdpo_pkg::LAST_BIT) begin
              next_state = sdpo_pkg::SDPO_GAP;
              next_cs_n = 1'b1;
              next_resp_word = rx_shift;
            end else begin
              next_bit_cnt = 5'(bit_cnt + 5'h01);
              next_tx_shift = {tx_shift[30:0], 1'b0};
              next_mosi = tx_shift[30];
            end
          end
        end
      end
      sdpo_pkg::SDPO_GAP: begin
        // gives the device time to decode before the next frame
        if (cnt == 5'(sdpo_pkg::GAP_CYCLES - 5'h01)) begin
          next_state = sdpo_pkg::SDPO_IDLE;
        end
      end
      default: begin
        next_state = sdpo_pkg::SDPO_IDLE;
        next_cs_n = 1'b1;
        next_sclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= sdpo_pkg::SDPO_IDLE;
      cnt <= 5'h00;
      bit_cnt <= 5'h00;
      tx_shift <= 32'h00000000;
      rx_shift <= 32'h00000000;
      resp_word <= 32'h00000000;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bit_cnt <= next_bit_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      resp_word <= next_resp_word;
      link.sclk <= next_sclk;
      link.cs_n <= next_cs_n;
      link.mosi <= next_mosi;
    end
  end

  logic unused_wstrb;
  assign unused_wstrb = ^s_axi_wstrb;
endmodule
`default_nettype wire

//--- pkg/sdpo_pkg.sv
// shared constants of the serial diagnostic-read and phase-offset link
package sdpo_pkg;
  // frame layout
  localparam int FRAME_BITS = 32;
  localparam int DIR_BIT = 31;
  localparam int ID_MSB = 30;
  localparam int ID_LSB = 24;
  localparam int DIAG_MSB = 23;
  localparam int OFFS_MSB = 19;
  localparam int OFFS_W = 5;
  localparam int OFFS_FIELDS_W = 20;
  localparam int DIAG_W = 24;
  // per-channel diag flag positions inside a six-bit channel slice
  localparam int GROUND_SHORT_POS = 5;
  localparam int GATE_OFF_TEST_POS = 4;
  localparam int BATTERY_SHORT_POS = 3;
  localparam int BATTERY_TEST_POS = 2;
  localparam int OPEN_OFF_POS = 1;
  localparam int OPEN_ON_POS = 0;
  // message identifiers
  localparam logic [6:0] ID_DIAG_LOW = 7'h04;
  localparam logic [6:0] ID_DIAG_HIGH = 7'h05;
  localparam logic [6:0] ID_OFFS_LOW = 7'h06;
  localparam logic [6:0] ID_OFFS_HIGH = 7'h07;
  // reset values
  localparam logic [23:0] DIAG_RESET = 24'h000000;
  localparam logic [19:0] OFFS_RESET = 20'h00000;
  localparam logic [31:0] RESP_RESET = 32'h00000000;
  // host timing in system clock cycles, and the last bit index of a frame
  localparam logic [4:0] HALF_CYCLES = 5'h04;
  localparam logic [4:0] GAP_CYCLES = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h1f;
  // host register byte offsets and axi response codes
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESP = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // host link sequencer
  typedef enum logic [1:0] {
    SDPO_IDLE = 2'h0,
    SDPO_LEAD = 2'h1,
    SDPO_SHIFT = 2'h3,
    SDPO_GAP = 2'h2
  } sdpo_state_t;
endpackage

//--- pkg/sdpo_link_if.sv
// four-wire serial link between the controller and the device
`timescale 1ns/1ps
`default_nettype none
interface sdpo_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport host (output sclk, output cs_n, output mosi, input miso);
  modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface
`default_nettype wire

//--- logic/sdpo_device.sv
// device end: frame decode, diagnostic status, pulse phase offsets
// Functional notes
// - diag read ignores direction, never alters status
// - identifier 04h selects diag channels 0-3
// - identifier 05h selects diag channels 4-7
// - diag answer: bit31 zero, identifier, 24 flags
// - ground short flags 23,17,11,5, reset zero
// - gate-off test done 22,16,10,4, reset zero
// - battery short flags 21,15,9,3, reset zero
// - battery test done 20,14,8,2, reset zero
// - open load gate-off 19,13,7,1, reset zero
// - open load gate-on 18,12,6,0, reset zero
// - identifier 06h: write when bit31 set, else read
// - four 5-bit offsets 19:0, reset zero
// - offsets applied only after phase-sync pulse
// - offset answer: bit31 zero, identifier, 23:20 zero
// - identifier 07h: same for channels 4-7
`timescale 1ns/1ps
`default_nettype none
module sdpo_device (
  // system clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  sdpo_link_if.dev link,
  // raw fault flags, six per channel, channel 0 in the top slice
  input wire logic [23:0] diag_low_in,
  input wire logic [23:0] diag_high_in,
  // channel alignment pin
  input wire logic phase_sync,
  // applied offsets and alignment pulse
  output logic [19:0] pulse_phase_delay_low,
  output logic [19:0] pulse_phase_delay_high,
  output logic channel_align
);
  // link domain state
  logic [4:0] bit_cnt;
  logic [30:0] rx_shift;
  logic [31:0] rx_word;
  logic rx_toggle;
  logic [4:0] next_bit_cnt;
  logic [30:0] next_rx_shift;
  logic [31:0] next_rx_word;
  logic next_rx_toggle;
  logic next_miso;
  // system domain state
  logic tog_s1, tog_s2, tog_s3;
  logic [23:0] diag_low_s1, diag_high_s1;
  logic [23:0] diag_status_group_low, diag_status_group_high;
  logic ps_s1, ps_s2, ps_s3;
  logic aligned;
  logic [19:0] pulse_phase_offsets_low, pulse_phase_offsets_high;
  logic [31:0] resp;
  logic [19:0] next_offs_low, next_offs_high;
  logic [31:0] next_resp;
  logic next_aligned;
  logic frame_seen;
  logic [6:0] rx_id;

  // bit counting and capture; counter restarts whenever select is high
  always_comb begin
    next_bit_cnt = 5'(bit_cnt + 5'h01);
    next_rx_shift = {rx_shift[29:0], link.mosi};
    next_rx_word = rx_word;
    next_rx_toggle = rx_toggle;
    if (bit_cnt == sdpo_pkg::LAST_BIT) begin
      next_rx_word = {rx_shift, link.mosi};
      next_rx_toggle = ~rx_toggle;
    end
  end

  always_ff @(posedge link.sclk or negedge resetn or posedge link.cs_n) begin
    if (!resetn) begin
      bit_cnt <= 5'h00;
      rx_shift <= 31'h00000000;
    end else if (link.cs_n) begin
      bit_cnt <= 5'h00;
      rx_shift <= 31'h00000000;
    end else begin
      bit_cnt <= next_bit_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // captured word is held until the next frame ends, toggle flags it
  always_ff @(posedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      rx_word <= sdpo_pkg::RESP_RESET;
      rx_toggle <= 1'b0;
    end else begin
      rx_word <= next_rx_word;
      rx_toggle <= next_rx_toggle;
    end
  end

  // answer bits leave on falling edges; resp is quiet during a frame
  always_comb begin
    next_miso = (bit_cnt == 5'h00) ? 1'b0 : resp[~bit_cnt];
  end

  always_ff @(negedge link.sclk or negedge resetn or posedge link.cs_n) begin
    if (!resetn) begin
      link.miso <= 1'b0;
    end else if (link.cs_n) begin
      link.miso <= 1'b0;
    end else begin
      link.miso <= next_miso;
    end
  end

  // pin and cross-domain synchronisers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      ps_s1 <= 1'b0;
      ps_s2 <= 1'b0;
      ps_s3 <= 1'b0;
      diag_low_s1 <= sdpo_pkg::DIAG_RESET;
      diag_high_s1 <= sdpo_pkg::DIAG_RESET;
      diag_status_group_low <= sdpo_pkg::DIAG_RESET;
      diag_status_group_high <= sdpo_pkg::DIAG_RESET;
    end else begin
      tog_s1 <= rx_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      ps_s1 <= phase_sync;
      ps_s2 <= ps_s1;
      ps_s3 <= ps_s2;
      diag_low_s1 <= diag_low_in;
      diag_high_s1 <= diag_high_in;
      diag_status_group_low <= diag_low_s1;
      diag_status_group_high <= diag_high_s1;
    end
  end

  assign frame_seen = tog_s2 ^ tog_s3;
  assign rx_id = rx_word[sdpo_pkg::ID_MSB:sdpo_pkg::ID_LSB];

  // decode one frame; unknown identifiers answer with all zeros
  always_comb begin
    next_offs_low = pulse_phase_offsets_low;
    next_offs_high = pulse_phase_offsets_high;
    next_resp = resp;
    next_aligned = aligned | (ps_s2 & ~ps_s3);
    if (frame_seen) begin
      case (rx_id)
        sdpo_pkg::ID_DIAG_LOW: begin
          next_resp = {1'b0, rx_id, diag_status_group_low};
        end
        sdpo_pkg::ID_DIAG_HIGH: begin
          next_resp = {1'b0, rx_id, diag_status_group_high};
        end
        sdpo_pkg::ID_OFFS_LOW: begin
          if (rx_word[sdpo_pkg::DIR_BIT]) begin
            next_offs_low = rx_word[sdpo_pkg::OFFS_MSB:0];
          end
          next_resp = {1'b0, rx_id, 4'h0, next_offs_low};
        end
        sdpo_pkg::ID_OFFS_HIGH: begin
          if (rx_word[sdpo_pkg::DIR_BIT]) begin
            next_offs_high = rx_word[sdpo_pkg::OFFS_MSB:0];
          end
          next_resp = {1'b0, rx_id, 4'h0, next_offs_high};
        end
        default: begin
          next_resp = sdpo_pkg::RESP_RESET;
        end
      endcase
    end
  end

  // offsets, answer and alignment; outputs stay zero until aligned
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pulse_phase_offsets_low <= sdpo_pkg::OFFS_RESET;
      pulse_phase_offsets_high <= sdpo_pkg::OFFS_RESET;
      resp <= sdpo_pkg::RESP_RESET;
      aligned <= 1'b0;
      channel_align <= 1'b0;
      pulse_phase_delay_low <= sdpo_pkg::OFFS_RESET;
      pulse_phase_delay_high <= sdpo_pkg::OFFS_RESET;
    end else begin
      pulse_phase_offsets_low <= next_offs_low;
      pulse_phase_offsets_high <= next_offs_high;
      resp <= next_resp;
      aligned <= next_aligned;
      channel_align <= ps_s2 & ~ps_s3;
      pulse_phase_delay_low <= next_aligned ? next_offs_low : sdpo_pkg::OFFS_RESET;
      pulse_phase_delay_high <= next_aligned ? next_offs_high : sdpo_pkg::OFFS_RESET;
    end
  end
endmodule
`default_nettype wire

//--- testbench/sdpo_link_asserts.sv
// link checker: framing, timing and answer layout seen on the serial wires
`timescale 1ns/1ps
`default_nettype none
module sdpo_link_asserts (
  // system clock and reset
  input wire logic clock,
  input wire logic resetn,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic sclk_d;
  logic cs_d;
  logic prev_ok;
  logic fin;
  logic [5:0] pulses;
  logic [31:0] mo_w;
  logic [31:0] mi_w;
  logic [31:0] prev_w;
  logic [6:0] pid;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // frame end, and the id of the frame before, which this answer must echo
  assign fin = cs_n && !cs_d;
  assign pid = prev_w[30:24];
  // capture both words on sclk rise, as the receiving ends do
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      prev_ok <= 1'b0;
      pulses <= 6'h00;
      mo_w <= 32'h00000000;
      mi_w <= 32'h00000000;
      prev_w <= 32'h00000000;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
      if (!cs_n && cs_d) begin
        pulses <= 6'h00;
      end else if (sclk && !sclk_d) begin
        pulses <= pulses + 6'h01;
        mo_w <= {mo_w[30:0], mosi};
        mi_w <= {mi_w[30:0], miso};
      end
      if (fin) begin
        prev_w <= mo_w;
        prev_ok <= 1'b1;
      end
    end
  end
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("sclk not low outside a frame");
  chk_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase not four clocks");
  // lead phase plus the first low half period keep sclk low for eight clocks
  chk_cs_lead: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first sclk rise not eight clocks after select");
  chk_mosi_held: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  chk_miso_on_fall: assert property ($changed(miso) |-> $fell(sclk))
    else $error("miso moved away from an sclk fall");
  chk_pulse_count: assert property (fin |-> pulses == 6'h20)
    else $error("frame without 32 sclk pulses");
  chk_gap_len: assert property ($rose(cs_n) |-> cs_n [*8] ##1 cs_n [*8])
    else $error("gap between frames too short");
  chk_first_zero: assert property ($fell(cs_n) |-> !miso)
    else $error("answer bit 31 not zero");
  chk_diag_echo: assert property (fin && prev_ok
    && (pid == sdpo_pkg::ID_DIAG_LOW || pid == sdpo_pkg::ID_DIAG_HIGH)
    |-> mi_w[31:24] == {1'b0, pid})
    else $error("diag answer header wrong");
  chk_offs_echo: assert property (fin && prev_ok && pid[6:1] == 6'h03
    |-> mi_w[31:20] == {1'b0, pid, 4'h0})
    else $error("offset answer header wrong");
  chk_offs_store: assert property (fin && prev_ok && prev_w[31] && pid[6:1] == 6'h03
    |-> mi_w[19:0] == prev_w[19:0])
    else $error("written offsets not answered back");
  chk_unknown_zero: assert property (fin && prev_ok && pid[6:2] != 5'h01
    |-> mi_w == 32'h00000000)
    else $error("answer to unknown id not zero");
  // main scenarios reached
  cov_diag_high: cover property (fin && pid == sdpo_pkg::ID_DIAG_HIGH);
  cov_offs_write: cover property (fin && prev_w[31] && pid == sdpo_pkg::ID_OFFS_HIGH);
  cov_unknown: cover property (fin && prev_ok && pid[6:2] != 5'h01);
endmodule
`default_nettype wire

//--- testbench/spi_diag_read_and_phase_offset_tb.sv
// testbench: both link ends joined, driven over axi4-lite and the device pins
`timescale 1ns/1ps
`default_nettype none
module spi_diag_read_and_phase_offset_tb;
  localparam logic [31:0] A_CMD = {28'h0000000, sdpo_pkg::REG_CMD};
  localparam logic [31:0] A_STAT = {28'h0000000, sdpo_pkg::REG_STATUS};
  localparam logic [31:0] A_RESP = {28'h0000000, sdpo_pkg::REG_RESP};
  localparam logic [19:0] OL = 20'hf82aa;
  localparam logic [19:0] OH = 20'h07d55;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [23:0] diag_low_in = 24'h0, diag_high_in = 24'h0;
  logic phase_sync = 1'b0;
  logic [19:0] pulse_phase_delay_low, pulse_phase_delay_high;
  logic channel_align;
  int num_errors = 0;
  int check_count = 0;
  logic [31:0] pend, rd;
  logic [1:0] rs;
  sdpo_link_if link ();
  sdpo_host sdpo_host_inst (.clock, .resetn, .link(link.host), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sdpo_device sdpo_device_inst (.clock, .resetn, .link(link.dev), .diag_low_in, .diag_high_in,
    .phase_sync, .pulse_phase_delay_low, .pulse_phase_delay_high, .channel_align);
  sdpo_link_asserts sdpo_link_asserts_inst (.clock, .resetn, .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));
  always #5 clock = ~clock;
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write master: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok) begin
      @(posedge clock);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b_ok = 1'b1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    // one idle edge so the next request never lands on the same step
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [31:0] a);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok) begin
      @(posedge clock);
      if (!ar_ok && s_axi_arready === 1'b1) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        r_ok = 1'b1;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    @(posedge clock);
  endtask
  // an answer shows up one frame late, so each frame judges the one before
  task automatic finish(input logic [31:0] ans);
    rd = 32'h00000001;
    while (rd[0] !== 1'b0) axi_rd(A_STAT);
    axi_rd(A_RESP);
    cmp("frame answer", pend, rd);
    pend = ans;
  endtask
  task automatic frame(input logic [31:0] w, input logic [31:0] ans);
    axi_wr(A_CMD, w);
    finish(ans);
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (2) @(posedge clock);
    pend = sdpo_pkg::RESP_RESET;
  endtask
  task automatic t_regs();
    axi_rd(A_RESP);
    cmp("resp reset", sdpo_pkg::RESP_RESET, rd);
    axi_rd(32'h0000000c);
    cmp("unmapped rresp", {30'h0, sdpo_pkg::RESP_SLVERR}, {30'h0, rs});
    cmp("unmapped rdata", 32'h0, rd);
    axi_wr(32'h0000000c, 32'hffffffff);
    cmp("unmapped bresp", {30'h0, sdpo_pkg::RESP_SLVERR}, {30'h0, rs});
    // a second command during a running frame is dropped
    axi_wr(A_CMD, {1'b0, sdpo_pkg::ID_OFFS_LOW, 24'h0});
    axi_wr(A_CMD, 32'h7f000000);
    cmp("busy bresp", {30'h0, sdpo_pkg::RESP_OKAY}, {30'h0, rs});
    finish({1'b0, sdpo_pkg::ID_OFFS_LOW, 24'h0});
    axi_rd(A_CMD);
    cmp("cmd readback", {1'b0, sdpo_pkg::ID_OFFS_LOW, 24'h0}, rd);
  endtask
  // walk each flag kind through all four channel slices of both groups
  task automatic t_diag();
    logic [23:0] p;
    for (int k = 0; k < 6; k++) begin
      p = 24'h820820 >> k;
      diag_low_in <= p;
      diag_high_in <= ~p;
      repeat (4) @(posedge clock);
      frame({k[0], sdpo_pkg::ID_DIAG_LOW, {24{k[0]}}}, {1'b0, sdpo_pkg::ID_DIAG_LOW, p});
      frame({1'b0, sdpo_pkg::ID_DIAG_HIGH, 24'h5a5a5a}, {1'b0, sdpo_pkg::ID_DIAG_HIGH, ~p});
    end
  endtask
  task automatic t_offs();
    int n;
    frame({1'b1, sdpo_pkg::ID_OFFS_LOW, 4'ha, OL}, {1'b0, sdpo_pkg::ID_OFFS_LOW, 4'h0, OL});
    frame({1'b1, sdpo_pkg::ID_OFFS_HIGH, 4'hf, OH}, {1'b0, sdpo_pkg::ID_OFFS_HIGH, 4'h0, OH});
    frame({1'b0, sdpo_pkg::ID_OFFS_LOW, 4'h0, 20'h12345}, {1'b0, sdpo_pkg::ID_OFFS_LOW, 4'h0, OL});
    cmp("delay before align", 32'h0, {12'h000, pulse_phase_delay_low});
    phase_sync <= 1'b1;
    n = 0;
    while (channel_align !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    cmp("align pulse", 32'h1, {31'h0, channel_align});
    @(posedge clock);
    phase_sync <= 1'b0;
    cmp("align width", 32'h0, {31'h0, channel_align});
    repeat (3) @(posedge clock);
    cmp("delay low", {12'h000, OL}, {12'h000, pulse_phase_delay_low});
    cmp("delay high", {12'h000, OH}, {12'h000, pulse_phase_delay_high});
    // after alignment the applied values follow each new write
    frame({1'b1, sdpo_pkg::ID_OFFS_LOW, 4'h0, OH}, {1'b0, sdpo_pkg::ID_OFFS_LOW, 4'h0, OH});
    cmp("delay tracks", {12'h000, OH}, {12'h000, pulse_phase_delay_low});
    frame({1'b1, 7'h08, 24'hffffff}, 32'h0);
    frame({1'b0, 7'h7f, 24'h0}, 32'h0);
  endtask
  // reset in mid-frame clears offsets and the need to realign returns
  task automatic t_reset();
    axi_wr(A_CMD, {1'b0, sdpo_pkg::ID_DIAG_LOW, 24'h0});
    repeat (60) @(posedge clock);
    do_reset();
    cmp("delay after reset", 32'h0, {12'h000, pulse_phase_delay_low});
    frame({1'b0, sdpo_pkg::ID_OFFS_LOW, 24'h0}, {1'b0, sdpo_pkg::ID_OFFS_LOW, 24'h0});
    frame({1'b1, sdpo_pkg::ID_OFFS_HIGH, 4'h0, OH}, {1'b0, sdpo_pkg::ID_OFFS_HIGH, 4'h0, OH});
    frame({1'b0, 7'h00, 24'h0}, 32'h0);
    cmp("no align no delay", 32'h0, {12'h000, pulse_phase_delay_high});
  endtask
  task automatic results();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    do_reset();
    t_regs();
    t_diag();
    t_offs();
    t_reset();
    results();
  end
  // watchdog: the full run needs well under this many clocks
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
